/* File: hw/cag_addr_gen.sv */
// cpu address generation: program counter and operand address forming
//
// Functional notes
// - sequential fetch adds instruction length to pc
// - relative branch adds signed displacement to next
// - long jump/call loads 16-bit immediate
// - short area call targets 0800h to 0fffh
// - table call loads entry from 40h-7fh
// - register jump loads pc from accumulator pair
// - multiply accumulator by register into pair
// - word divide uses accumulator pair implicitly
// - decimal adjust implicitly targets the accumulator
// - digit rotates implicitly use the accumulator
// - register operands selected by code and bank
// - direct addressing uses 16-bit immediate address
// - short direct reaches fe20h to ff1fh window
// - offset below 20h sets address bit eight
// - window holds ram then special registers
`include "cag_defs.svh"

module cag_addr_gen (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic start,
	input wire cag_pkg::cag_pc_mode_t pc_mode,
	input wire cag_pkg::cag_op_mode_t op_mode,
	input wire logic [2:0] instr_len,
	input wire logic [7:0] branch_displacement,
	input wire logic [15:0] full_address_immediate,
	input wire logic [10:0] short_call_immediate,
	input wire logic [7:0] table_opcode,
	input wire logic [15:0] accumulator_pair,
	input wire logic [15:0] table_entry,
	input wire logic table_entry_valid,
	input wire logic [2:0] reg_code,
	input wire logic [1:0] pair_code,
	input wire logic bank_select_low,
	input wire logic bank_select_high,
	input wire logic [7:0] short_offset,
	input wire logic [7:0] multiplier_value,
	output logic [15:0] program_counter,
	output logic busy,
	output logic done,
	output logic table_read,
	output logic [15:0] table_addr,
	output logic [15:0] operand_addr,
	output logic operand_addr_valid,
	output logic operand_is_sfr,
	output logic [4:0] reg8_index,
	output logic reg8_valid,
	output logic [3:0] pair_index,
	output logic pair_valid,
	output logic [15:0] product,
	output logic product_valid
);
	import cag_pkg::*;

	// ----------------------------------------------------------------
	// helper functions
	// ----------------------------------------------------------------

	// byte register index inside the selected bank
	function automatic logic [4:0] reg8_of(input logic [1:0] bank, input logic [2:0] code);
		reg8_of = {bank, code};
	endfunction

	// register pair index inside the selected bank
	function automatic logic [3:0] pair_of(input logic [1:0] bank, input logic [1:0] code);
		pair_of = {bank, code};
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	cag_state_t state_reg, state_next;
	logic [15:0] pc_reg, pc_next;
	logic done_reg, done_next;
	logic table_read_reg, table_read_next;
	logic [15:0] table_addr_reg, table_addr_next;
	logic [15:0] operand_addr_reg, operand_addr_next;
	logic operand_valid_reg, operand_valid_next;
	logic operand_sfr_reg, operand_sfr_next;
	logic [4:0] reg8_index_reg, reg8_index_next;
	logic reg8_valid_reg, reg8_valid_next;
	logic [3:0] pair_index_reg, pair_index_next;
	logic pair_valid_reg, pair_valid_next;
	logic [15:0] product_reg, product_next;
	logic product_valid_reg, product_valid_next;

	logic [1:0] bank;
	logic [15:0] next_instr_addr;
	logic [15:0] disp_ext;
	logic accept;

	assign bank = {bank_select_high, bank_select_low};
	// a new request is only taken while no table fetch is pending
	assign accept = start && (state_reg == CAG_IDLE);
	assign next_instr_addr = pc_reg + {13'h0, instr_len};
	assign disp_ext = {{8{branch_displacement[7]}}, branch_displacement};

	// ----------------------------------------------------------------
	// program counter sequencing
	// ----------------------------------------------------------------

	// next pc and table fetch handshake
	always_comb begin
		state_next = state_reg;
		pc_next = pc_reg;
		done_next = 1'b0;
		table_read_next = 1'b0;
		table_addr_next = table_addr_reg;
		unique case (state_reg)
			CAG_IDLE: begin
				if (accept) begin
					done_next = 1'b1;
					unique case (pc_mode)
						CAG_PC_HOLD: begin
							pc_next = pc_reg;
						end
						CAG_PC_SEQ: begin
							pc_next = next_instr_addr;
						end
						CAG_PC_REL: begin
							pc_next = next_instr_addr + disp_ext;
						end
						CAG_PC_IMM16: begin
							pc_next = full_address_immediate;
						end
						CAG_PC_SHORT_CALL: begin
							pc_next = `CAG_SHORT_CALL_BASE | {5'h0, short_call_immediate};
						end
						CAG_PC_TABLE: begin
							done_next = 1'b0;
							table_read_next = 1'b1;
							table_addr_next = `CAG_TABLE_BASE | {10'h0, table_opcode[5:1], 1'b0};
							state_next = CAG_TABLE_WAIT;
						end
						CAG_PC_REG_JUMP: begin
							pc_next = accumulator_pair;
						end
						default: begin
							pc_next = pc_reg;
						end
					endcase
				end
			end
			CAG_TABLE_WAIT: begin
				// hold the read request until memory answers
				table_read_next = ~table_entry_valid;
				if (table_entry_valid) begin
					pc_next = table_entry;
					done_next = 1'b1;
					state_next = CAG_IDLE;
				end
			end
		endcase
	end

	// pc group registers
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= CAG_IDLE;
			pc_reg <= `CAG_PC_RESET;
			done_reg <= 1'b0;
			table_read_reg <= 1'b0;
			table_addr_reg <= 16'h0000;
		end else begin
			state_reg <= state_next;
			pc_reg <= pc_next;
			done_reg <= done_next;
			table_read_reg <= table_read_next;
			table_addr_reg <= table_addr_next;
		end
	end

	// ----------------------------------------------------------------
	// operand addressing
	// ----------------------------------------------------------------

	// operand address, register selects and multiply result
	always_comb begin
		operand_addr_next = operand_addr_reg;
		operand_valid_next = 1'b0;
		operand_sfr_next = 1'b0;
		reg8_index_next = reg8_index_reg;
		reg8_valid_next = 1'b0;
		pair_index_next = pair_index_reg;
		pair_valid_next = 1'b0;
		product_next = product_reg;
		product_valid_next = 1'b0;
		if (accept) begin
			unique case (op_mode)
				CAG_OP_NONE: begin
					operand_valid_next = 1'b0;
				end
				CAG_OP_MULTIPLY: begin
					reg8_index_next = reg8_of(bank, `CAG_REG_CODE_A);
					reg8_valid_next = 1'b1;
					pair_index_next = pair_of(bank, `CAG_PAIR_CODE_AX);
					pair_valid_next = 1'b1;
					product_next = accumulator_pair[15:8] * multiplier_value;
					product_valid_next = 1'b1;
				end
				CAG_OP_DIVIDE: begin
					pair_index_next = pair_of(bank, `CAG_PAIR_CODE_AX);
					pair_valid_next = 1'b1;
				end
				CAG_OP_DECIMAL_ADJUST, CAG_OP_DIGIT_ROTATE: begin
					reg8_index_next = reg8_of(bank, `CAG_REG_CODE_A);
					reg8_valid_next = 1'b1;
				end
				CAG_OP_REG8: begin
					reg8_index_next = reg8_of(bank, reg_code);
					reg8_valid_next = 1'b1;
				end
				CAG_OP_REG16: begin
					pair_index_next = pair_of(bank, pair_code);
					pair_valid_next = 1'b1;
				end
				CAG_OP_DIRECT: begin
					operand_addr_next = full_address_immediate;
					operand_valid_next = 1'b1;
				end
				CAG_OP_SHORT_DIRECT: begin
					operand_addr_next = {`CAG_SHORT_DIRECT_HIGH,
						short_offset < `CAG_SHORT_SFR_LIMIT, short_offset};
					operand_valid_next = 1'b1;
					// upper part of window is sfr
					operand_sfr_next = short_offset < `CAG_SHORT_SFR_LIMIT;
				end
				default: begin
					operand_valid_next = 1'b0;
				end
			endcase
		end
	end

	// operand group registers
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			operand_addr_reg <= 16'h0000;
			operand_valid_reg <= 1'b0;
			operand_sfr_reg <= 1'b0;
			reg8_index_reg <= 5'h00;
			reg8_valid_reg <= 1'b0;
			pair_index_reg <= 4'h0;
			pair_valid_reg <= 1'b0;
			product_reg <= 16'h0000;
			product_valid_reg <= 1'b0;
		end else begin
			operand_addr_reg <= operand_addr_next;
			operand_valid_reg <= operand_valid_next;
			operand_sfr_reg <= operand_sfr_next;
			reg8_index_reg <= reg8_index_next;
			reg8_valid_reg <= reg8_valid_next;
			pair_index_reg <= pair_index_next;
			pair_valid_reg <= pair_valid_next;
			product_reg <= product_next;
			product_valid_reg <= product_valid_next;
		end
	end

	// ----------------------------------------------------------------
	// outputs, all straight from flip-flops
	// ----------------------------------------------------------------
	assign program_counter = pc_reg;
	assign busy = (state_reg == CAG_TABLE_WAIT); // state flop decodes to one bit
	assign done = done_reg;
	assign table_read = table_read_reg;
	assign table_addr = table_addr_reg;
	assign operand_addr = operand_addr_reg;
	assign operand_addr_valid = operand_valid_reg;
	assign operand_is_sfr = operand_sfr_reg;
	assign reg8_index = reg8_index_reg;
	assign reg8_valid = reg8_valid_reg;
	assign pair_index = pair_index_reg;
	assign pair_valid = pair_valid_reg;
	assign product = product_reg;
	assign product_valid = product_valid_reg;

endmodule // cag_addr_gen

/* File: hw/cag_defs.svh */
// constants for the cpu address generation block
`ifndef CAG_DEFS_SVH
`define CAG_DEFS_SVH

`define CAG_PC_RESET 16'h0000
`define CAG_SHORT_CALL_BASE 16'h0800
`define CAG_TABLE_BASE 16'h0040
`define CAG_SHORT_DIRECT_HIGH 7'h7f
`define CAG_SHORT_SFR_LIMIT 8'h20
`define CAG_REG_CODE_X 3'h0
`define CAG_REG_CODE_A 3'h1
`define CAG_PAIR_CODE_AX 2'h0

`endif

/* File: hw/cag_pkg.sv */
// types shared by the cpu address generation block
package cag_pkg;

	// program counter update forms
	typedef enum logic [2:0] {
		CAG_PC_HOLD,
		CAG_PC_SEQ,
		CAG_PC_REL,
		CAG_PC_IMM16,
		CAG_PC_SHORT_CALL,
		CAG_PC_TABLE,
		CAG_PC_REG_JUMP
	} cag_pc_mode_t;

	// operand addressing forms
	typedef enum logic [3:0] {
		CAG_OP_NONE,
		CAG_OP_MULTIPLY,
		CAG_OP_DIVIDE,
		CAG_OP_DECIMAL_ADJUST,
		CAG_OP_DIGIT_ROTATE,
		CAG_OP_REG8,
		CAG_OP_REG16,
		CAG_OP_DIRECT,
		CAG_OP_SHORT_DIRECT
	} cag_op_mode_t;

	// sequencer states
	typedef enum logic {
		CAG_IDLE,
		CAG_TABLE_WAIT
	} cag_state_t;

endpackage : cag_pkg

/* File: tb/cag_addr_gen_asserts.sv */
// port assertions for the cpu address generation block
module cag_addr_gen_asserts
	import cag_pkg::*;
(
	input wire logic clock,
	input wire logic rst_b,
	input wire logic start,
	input wire logic busy,
	input wire logic done,
	input wire logic table_read,
	input wire logic table_entry_valid,
	input wire logic operand_is_sfr,
	input wire logic product_valid,
	input wire cag_pkg::cag_pc_mode_t pc_mode,
	input wire cag_pkg::cag_op_mode_t op_mode,
	input wire logic [2:0] instr_len,
	input wire logic [7:0] branch_displacement,
	input wire logic [7:0] table_opcode,
	input wire logic [7:0] short_offset,
	input wire logic [7:0] multiplier_value,
	input wire logic [10:0] short_call_immediate,
	input wire logic [15:0] full_address_immediate,
	input wire logic [15:0] accumulator_pair,
	input wire logic [15:0] table_entry,
	input wire logic [15:0] program_counter,
	input wire logic [15:0] table_addr,
	input wire logic [15:0] operand_addr,
	input wire logic [15:0] product
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clock);
	endclocking
	default disable iff (!rst_b);

	// helper terms; $past cannot take a slice, so widen first
	logic go;
	logic [5:0] slot_off;
	logic [15:0] disp_ext;
	assign go = start && !busy;
	assign slot_off = {table_opcode[5:1], 1'b0};
	assign disp_ext = {{8{branch_displacement[7]}}, branch_displacement};

	chk_seq_step: assert property (go && pc_mode == CAG_PC_SEQ |=> done &&
		program_counter == $past(program_counter) + $past(instr_len)) else $error("pc step wrong");
	chk_rel_target: assert property (go && pc_mode == CAG_PC_REL |=>
		program_counter == $past(program_counter) + $past(instr_len) + $past(disp_ext)) else $error("rel wrong");
	chk_imm_load: assert property (go && pc_mode == CAG_PC_IMM16 |=>
		program_counter == $past(full_address_immediate)) else $error("imm16 wrong");
	chk_short_call: assert property (go && pc_mode == CAG_PC_SHORT_CALL |=>
		program_counter == {5'h01, $past(short_call_immediate)}) else $error("short call wrong");
	chk_table_addr: assert property (go && pc_mode == CAG_PC_TABLE |=>
		table_read && busy && table_addr == {10'h001, $past(slot_off)}) else $error("table addr wrong");
	chk_table_load: assert property (busy && table_entry_valid |=>
		done && !busy && program_counter == $past(table_entry)) else $error("table load wrong");
	chk_mul_product: assert property (go && op_mode == CAG_OP_MULTIPLY |=> product_valid &&
		product == ($past(accumulator_pair) >> 8) * $past(multiplier_value)) else $error("product wrong");
	chk_short_direct: assert property (go && op_mode == CAG_OP_SHORT_DIRECT |=>
		operand_addr == {7'h7f, $past(short_offset) < 8'h20, $past(short_offset)} &&
		operand_is_sfr == ($past(short_offset) < 8'h20)) else $error("short direct wrong");
endmodule // cag_addr_gen_asserts

bind cag_addr_gen cag_addr_gen_asserts u_chk (.*);

/* File: tb/tb.sv */
// self-checking bench for the cpu address generation block
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import cag_pkg::*;
	logic clock, rst_b, start, table_entry_valid, bank_select_low, bank_select_high, busy, done, table_read;
	logic operand_addr_valid, operand_is_sfr, reg8_valid, pair_valid, product_valid;
	cag_pc_mode_t pc_mode;
	cag_op_mode_t op_mode;
	logic [1:0] pair_code, bank;
	logic [2:0] instr_len, reg_code;
	logic [3:0] pair_index;
	logic [4:0] reg8_index;
	logic [7:0] branch_displacement, table_opcode, short_offset, multiplier_value;
	logic [7:0] corner [4] = '{8'h00, 8'h1f, 8'h20, 8'hff};
	logic [10:0] short_call_immediate;
	logic [15:0] full_address_immediate, accumulator_pair, table_entry, program_counter, table_addr;
	logic [15:0] operand_addr, product, exp_pc;
	logic [31:0] r;
	integer seed = 32'h27bc;
	int num_errors = 0;
	int n_tests = 0;
	assign bank = {bank_select_high, bank_select_low};
	cag_addr_gen dut (
		.clock(clock),
		.rst_b(rst_b),
		.start(start),
		.pc_mode(pc_mode),
		.op_mode(op_mode),
		.instr_len(instr_len),
		.branch_displacement(branch_displacement),
		.full_address_immediate(full_address_immediate),
		.short_call_immediate(short_call_immediate),
		.table_opcode(table_opcode),
		.accumulator_pair(accumulator_pair),
		.table_entry(table_entry),
		.table_entry_valid(table_entry_valid),
		.reg_code(reg_code),
		.pair_code(pair_code),
		.bank_select_low(bank_select_low),
		.bank_select_high(bank_select_high),
		.short_offset(short_offset),
		.multiplier_value(multiplier_value),
		.program_counter(program_counter),
		.busy(busy),
		.done(done),
		.table_read(table_read),
		.table_addr(table_addr),
		.operand_addr(operand_addr),
		.operand_addr_valid(operand_addr_valid),
		.operand_is_sfr(operand_is_sfr),
		.reg8_index(reg8_index),
		.reg8_valid(reg8_valid),
		.pair_index(pair_index),
		.pair_valid(pair_valid),
		.product(product),
		.product_valid(product_valid)
	);

	// ----------------------------------------
	// clock, watchdog, checking helpers
	// ----------------------------------------
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	// run needs about 800 cycles, so 10000 means a hang
	initial begin
		#100000;
		num_errors++;
		finish_test;
	end
	task chk(input logic [23:0] got, input logic [23:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task finish_test;
		if (num_errors == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// model pc; sums wrap at sixteen bits
	function automatic logic [15:0] f_pc(input cag_pc_mode_t m);
		case (m)
			CAG_PC_SEQ: return exp_pc + {13'h0, instr_len};
			CAG_PC_REL: return exp_pc + {13'h0, instr_len} + {{8{branch_displacement[7]}}, branch_displacement};
			CAG_PC_IMM16: return full_address_immediate;
			CAG_PC_SHORT_CALL: return {5'h01, short_call_immediate};
			CAG_PC_REG_JUMP: return accumulator_pair;
			default: return exp_pc;
		endcase
	endfunction
	function automatic logic [17:0] f_sd(input logic [7:0] s);
		return {1'b1, s < 8'h20, 7'h7f, s < 8'h20, s};
	endfunction
	// one request; start stays up so calls run back to back
	task automatic op(input cag_pc_mode_t pm, input cag_op_mode_t om, input bit rnd);
		if (rnd) begin
			r = $random(seed);
			{branch_displacement, short_offset, multiplier_value, table_opcode} = r;
			r = $random(seed);
			{full_address_immediate, accumulator_pair} = r;
			r = $random(seed);
			{table_entry, short_call_immediate, reg_code, pair_code} = r;
			r = $random(seed);
			{bank_select_low, bank_select_high} = r[3:2];
			instr_len = 3'h1 + {1'b0, r[1:0]};
		end
		pc_mode = pm;
		op_mode = om;
		start = 1'b1;
		exp_pc = (pm == CAG_PC_TABLE) ? table_entry : f_pc(pm);
		@(negedge clock);
		case (om)
			CAG_OP_MULTIPLY: begin
				chk(product, accumulator_pair[15:8] * multiplier_value);
				chk({product_valid, reg8_valid, reg8_index}, {2'h3, bank, 3'h1});
				chk({pair_valid, pair_index}, {1'b1, bank, 2'h0});
			end
			CAG_OP_DIVIDE: begin
				chk({pair_valid, pair_index}, {1'b1, bank, 2'h0});
			end
			CAG_OP_DECIMAL_ADJUST, CAG_OP_DIGIT_ROTATE: begin
				chk({reg8_valid, reg8_index}, {1'b1, bank, 3'h1});
			end
			CAG_OP_REG8: begin
				chk({reg8_valid, reg8_index}, {1'b1, bank, reg_code});
			end
			CAG_OP_REG16: begin
				chk({pair_valid, pair_index}, {1'b1, bank, pair_code});
			end
			CAG_OP_DIRECT: begin
				chk({operand_addr_valid, operand_addr}, {1'b1, full_address_immediate});
			end
			CAG_OP_SHORT_DIRECT: begin
				chk({operand_addr_valid, operand_is_sfr, operand_addr}, f_sd(short_offset));
			end
			default: ;
		endcase
		// vector fetch; a start while busy must be ignored
		if (pm == CAG_PC_TABLE) begin
			chk({table_read, busy, table_addr}, {2'h3, 10'h001, table_opcode[5:1], 1'b0});
			pc_mode = CAG_PC_SEQ;
			repeat (r[1:0]) @(negedge clock);
			table_entry_valid = 1'b1;
			@(negedge clock);
			table_entry_valid = 1'b0;
		end
		// every mode must leave done high, busy low and the pc where the model puts it
		chk({done, busy, program_counter}, {2'h2, exp_pc});
	endtask

	// ----------------------------------------
	// main sequence: corners, then random
	// ----------------------------------------
	initial begin
		{start, table_entry_valid, rst_b, bank_select_low, bank_select_high, pair_code, instr_len, reg_code} = '0;
		{branch_displacement, table_opcode, short_offset, multiplier_value, short_call_immediate} = '0;
		{full_address_immediate, accumulator_pair, table_entry, exp_pc, r} = '0;
		pc_mode = CAG_PC_HOLD;
		op_mode = CAG_OP_NONE;
		repeat (10) @(negedge clock);
		rst_b = 1'b1;
		full_address_immediate = 16'hfffe;
		op(CAG_PC_IMM16, CAG_OP_DIRECT, 0);
		branch_displacement = 8'h7f;
		instr_len = 3'h4;
		op(CAG_PC_REL, CAG_OP_NONE, 0);
		branch_displacement = 8'h80;
		repeat (2) op(CAG_PC_REL, CAG_OP_NONE, 0);
		// window edges and first and last vector slots
		for (int i = 0; i < 4; i++) begin
			short_offset = corner[i];
			table_opcode = corner[i];
			op(CAG_PC_TABLE, CAG_OP_SHORT_DIRECT, 0);
		end
		// a word operand sits at an even offset
		short_offset = 8'h1e;
		op(CAG_PC_HOLD, CAG_OP_SHORT_DIRECT, 0);
		accumulator_pair = 16'hff00;
		multiplier_value = 8'hff;
		op(CAG_PC_SEQ, CAG_OP_MULTIPLY, 0);
		// a stray vector word while idle must not move the pc
		start = 1'b0;
		table_entry = 16'h1234;
		table_entry_valid = 1'b1;
		@(negedge clock);
		table_entry_valid = 1'b0;
		chk({done, busy, table_read, program_counter}, {3'h0, exp_pc});
		repeat (400) begin
			r = $random(seed);
			if (r[31]) begin
				start = 1'b0;
				@(negedge clock);
			end
			op(cag_pc_mode_t'(r[15:8] % 7), cag_op_mode_t'(r[7:0] % 9), 1);
		end
		start = 1'b0;
		finish_test;
	end
endmodule // tb
